// ---- rtl/xfer_consts.svh ----
// What this block does
// - host-end option bit, enabled after reset
// - option on: pin four carries host end
// - host end from FIFO bit 18 or zero
// - status bit shows live host-end pin level
// - host end low after reset
// - output: FIFO bit 18 low drives host end
// - output: stays low until FIFO reset, reload
// - input: low right after last asserting edge
// - low while zero; load or preset releases
// - host end never blocks handshakes itself
// - input without counter, option on: pin left undriven
// - 24-bit down counter, zero below 0x010000
// - counter bytes at registers A, B upper
// - reset: max count, held, irq off, load 1
// - holding register changes only on writes
// - count reset 1 holds counter, no counting
// - zero irq disable 0 lets zero set flag
// - load 1 copies holding; count when 0
// - decrement on falling control edge, zero stops
// - zero irq only after control deasserted
// - backplane status register read clears attention flag
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH

// register offsets on the local register port
`define OFS_CTL_STATUS 4'h7
`define OFS_BP_STATUS 4'h9
`define OFS_COUNT_LM 4'ha
`define OFS_COUNT_HI_CTL2 4'hb

// field positions, control register (offset 7)
`define CTL_ZERO_IRQ_DIS_BIT 0
`define CTL_LOAD_BIT 1
`define CTL_OUT_FOUR_BIT 4
`define CTL_DIR_BIT 7
// field positions, status register (offset 7 read)
`define STA_ZERO_BIT 0
`define STA_HOST_END_BIT 1
// field positions, second control register (offset b lower)
`define CTL2_COUNT_RESET_BIT 0
`define CTL2_HOST_END_OUT_ENABLE_BIT 1

// reset values
`define RST_COUNT 24'hffffff
`define RST_ZERO_IRQ_DIS 1'b1
`define RST_LOAD 1'b1
`define RST_COUNT_RESET 1'b1
`define RST_HOST_END_OUT_ENABLE 1'b1
`define RST_DIR 1'b1
`define RST_OUT_FOUR 1'b0

`endif

// ---- rtl/xfer_pkg.sv ----
package xfer_pkg;
    // counter word
    typedef logic [23:0] count_type;
    // register data word
    typedef logic [15:0] data_type;
    // register port address
    typedef logic [3:0] addr_type;
    // what drives frontplane pin four
    typedef enum logic [1:0] {SRC_CONTROL, SRC_HOST_END, SRC_NONE} pin_src_type;
endpackage

// ---- rtl/attention_flag.sv ----
// edge-triggered attention flag, cleared by status reads
module attention_flag (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // sources and clear
    input wire logic i_src_any,
    input wire logic i_clear,
    // flag out
    output logic o_flag
);
    logic src_prev_r; // last sampled or of sources
    logic flag_r; // the flag itself
    logic rise; // new rising edge on the sources

    // only a fresh rise sets the flag, so a source held high cannot re-set it
    assign rise = i_src_any & ~src_prev_r;

    // the clear beats a same-cycle rise: a read in progress blocks setting
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            src_prev_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            src_prev_r <= i_src_any;
            if (i_clear) begin
                flag_r <= 1'b0;
            end else if (rise) begin
                flag_r <= 1'b1;
            end
        end
    end

    assign o_flag = flag_r;
endmodule

// ---- rtl/count_stage.sv ----
`include "xfer_consts.svh"
// holding register plus the counting stage
module count_stage #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // holding register writes
    input wire logic i_wr_low_mid,
    input wire logic i_wr_high,
    input wire logic [15:0] i_wdata,
    // controls
    input wire logic i_count_reset,
    input wire logic i_load,
    input wire logic i_dec,
    // state out
    output logic [WIDTH-1:0] o_count,
    output logic [WIDTH-1:0] o_hold
);
    logic [WIDTH-1:0] hold_r; // software-written value
    logic [WIDTH-1:0] count_r; // counting stage
    logic [WIDTH-1:0] count_nxt; // next count
    logic is_zero; // logical zero: upper byte clear

    // the holding register only ever moves on a software write
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hold_r <= WIDTH'(`RST_COUNT);
        end else begin
            if (i_wr_low_mid) begin
                hold_r[15:0] <= i_wdata;
            end
            if (i_wr_high) begin
                hold_r[WIDTH-1:16] <= i_wdata[WIDTH-9:8];
            end
        end
    end

    assign is_zero = (count_r[WIDTH-1:16] == '0);

    // reset wins over load, load over counting; stop at zero so no wrap
    always_comb begin
        count_nxt = count_r;
        if (i_count_reset) begin
            count_nxt = WIDTH'(`RST_COUNT);
        end else if (i_load) begin
            count_nxt = hold_r;
        end else if (i_dec && !is_zero) begin
            count_nxt = count_r - WIDTH'(1);
        end
    end

    // counting stage register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count_r <= WIDTH'(`RST_COUNT);
        end else begin
            count_r <= count_nxt;
        end
    end

    assign o_count = count_r;
    assign o_hold = hold_r;
endmodule

// ---- rtl/transfer_counter_end_signal.sv ----
`include "xfer_consts.svh"
// transfer counter and host-end signalling of the parallel adapter
module transfer_counter_end_signal (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // local register port
    input wire xfer_pkg::addr_type i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire xfer_pkg::data_type i_reg_wdata,
    output xfer_pkg::data_type o_reg_rdata,
    // frontplane handshake side, same clock
    input wire logic i_handshake_control_out,
    input wire logic i_peripheral_end_in,
    input wire logic i_frontplane_disable,
    // fifo and other interrupt sources
    input wire logic i_fifo_bit18,
    input wire logic i_other_irq_src,
    // handshake gating
    output logic o_handshake_enable,
    // frontplane pin four
    output logic o_pin_four,
    output logic o_pin_four_oe,
    // status towards the rest of the card
    output logic o_host_end_out,
    output logic o_zero_count,
    output logic o_count_irq_src,
    output logic o_transfer_direction_bit,
    output logic o_attention_request_flag
);
    import xfer_pkg::*;

    // decoded register strobes
    wire wr_ctl; // write of control register
    wire wr_count_lm; // write of counter low and middle bytes
    wire wr_count_hi; // write of counter high byte and second control
    wire rd_ctl; // read of status register
    wire rd_bp_status; // read of backplane status register
    wire rd_count_lm; // read of counter low and middle bytes
    wire rd_count_hi; // read of counter high byte

    // control bits written by software
    logic zero_irq_disable_r; // zero interrupt disable
    logic load_r; // load control, 1 makes the counter transparent
    logic count_reset_r; // count reset, 1 holds the counter
    logic host_end_out_enable_r; // host-end option select
    logic transfer_direction_bit_r; // 1 input, 0 output
    logic control_output_four_r; // plain control bit for pin four

    // counter state
    count_type count; // counting stage value
    count_type hold; // holding register value
    wire zero; // logical zero of the counter
    wire counter_used; // counter is out of reset

    // handshake control edge detection
    logic hs_prev_r; // last value of the control output
    wire hs_fall; // deasserted-to-asserted edge

    // pin four computation
    pin_src_type pin_src; // who drives pin four now
    logic host_end_nxt; // next host-end level
    logic pin_four_nxt; // next pin level
    logic pin_four_oe_nxt; // next pin enable
    logic host_end_r; // host-end level register
    logic pin_four_r; // pin level register
    logic pin_four_oe_r; // pin enable register

    // read data
    data_type rdata_nxt; // read mux output
    data_type rdata_r; // registered read data

    // interrupt source
    wire count_irq_src; // counter asks for attention

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------

    // address compare against the printed offsets
    assign wr_ctl = i_reg_wr && (i_reg_addr == `OFS_CTL_STATUS);
    assign wr_count_lm = i_reg_wr && (i_reg_addr == `OFS_COUNT_LM);
    assign wr_count_hi = i_reg_wr && (i_reg_addr == `OFS_COUNT_HI_CTL2);
    assign rd_ctl = i_reg_rd && (i_reg_addr == `OFS_CTL_STATUS);
    assign rd_bp_status = i_reg_rd && (i_reg_addr == `OFS_BP_STATUS);
    assign rd_count_lm = i_reg_rd && (i_reg_addr == `OFS_COUNT_LM);
    assign rd_count_hi = i_reg_rd && (i_reg_addr == `OFS_COUNT_HI_CTL2);

    // ------------------------------------------------------------------
    // control register (offset 7)
    // ------------------------------------------------------------------

    // whole-word write; unused bits belong to other logic of the card
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            zero_irq_disable_r <= `RST_ZERO_IRQ_DIS;
            load_r <= `RST_LOAD;
            transfer_direction_bit_r <= `RST_DIR;
            control_output_four_r <= `RST_OUT_FOUR;
        end else if (wr_ctl) begin
            zero_irq_disable_r <= i_reg_wdata[`CTL_ZERO_IRQ_DIS_BIT];
            load_r <= i_reg_wdata[`CTL_LOAD_BIT];
            transfer_direction_bit_r <= i_reg_wdata[`CTL_DIR_BIT];
            control_output_four_r <= i_reg_wdata[`CTL_OUT_FOUR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // second control register (offset b, lower byte)
    // ------------------------------------------------------------------

    // the upper byte of the same write goes to the holding register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count_reset_r <= `RST_COUNT_RESET;
            host_end_out_enable_r <= `RST_HOST_END_OUT_ENABLE;
        end else if (wr_count_hi) begin
            count_reset_r <= i_reg_wdata[`CTL2_COUNT_RESET_BIT];
            host_end_out_enable_r <= i_reg_wdata[`CTL2_HOST_END_OUT_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // handshake edge detection
    // ------------------------------------------------------------------

    // control output is our own logic, same clock, so no synchroniser
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hs_prev_r <= 1'b1; // deasserted high at reset
        end else begin
            hs_prev_r <= i_handshake_control_out;
        end
    end

    // high-to-low is the asserting edge
    assign hs_fall = hs_prev_r & ~i_handshake_control_out;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------

    // holding register and counting stage live in their own module
    count_stage #(
        .WIDTH(24)
    ) u_count (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_wr_low_mid(wr_count_lm),
        .i_wr_high(wr_count_hi),
        .i_wdata(i_reg_wdata),
        .i_count_reset(count_reset_r),
        .i_load(load_r),
        .i_dec(hs_fall),
        .o_count(count),
        .o_hold(hold)
    );

    // logical zero covers 0 .. 0x00ffff, i.e. the upper byte is clear
    assign zero = (count[23:16] == 8'h00);
    // a counter held in reset is not taking part in the transfer
    assign counter_used = ~count_reset_r;

    // ------------------------------------------------------------------
    // handshake gating
    // ------------------------------------------------------------------

    // host end is deliberately absent here; it must not stop handshakes
    assign o_handshake_enable = ~(zero & counter_used)
        & ~i_peripheral_end_in
        & ~i_frontplane_disable;

    // ------------------------------------------------------------------
    // host-end level
    // ------------------------------------------------------------------

    // output: fifo bit 18 carries the end mark with data timing, the
    // zero count reinforces it; input: the counter alone decides
    always_comb begin
        host_end_nxt = 1'b1;
        if (!transfer_direction_bit_r) begin
            // output transfer, either source pulls it low
            host_end_nxt = i_fifo_bit18 & ~(zero & counter_used);
        end else if (counter_used) begin
            // input transfer, low from the edge that took the last count
            host_end_nxt = ~zero;
        end else begin
            // input without counter: level kept low, pin released below when the option is on
            host_end_nxt = 1'b0;
        end
    end

    // which source owns pin four
    always_comb begin
        pin_src = SRC_CONTROL;
        if (host_end_out_enable_r) begin
            if (transfer_direction_bit_r && !counter_used) begin
                pin_src = SRC_NONE;
            end else begin
                pin_src = SRC_HOST_END;
            end
        end
    end

    // pin level and enable per source
    always_comb begin
        pin_four_nxt = control_output_four_r;
        pin_four_oe_nxt = 1'b1;
        case (pin_src)
            SRC_CONTROL: begin
                pin_four_nxt = control_output_four_r;
                pin_four_oe_nxt = 1'b1;
            end
            SRC_HOST_END: begin
                pin_four_nxt = host_end_nxt;
                pin_four_oe_nxt = 1'b1;
            end
            SRC_NONE: begin
                pin_four_nxt = 1'b0;
                pin_four_oe_nxt = 1'b0;
            end
            default: begin
                pin_four_nxt = control_output_four_r;
                pin_four_oe_nxt = 1'b1;
            end
        endcase
    end

    // pin registers; reset drives the pin low, same as the cleared fifo
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            host_end_r <= 1'b0;
            pin_four_r <= 1'b0;
            pin_four_oe_r <= 1'b1;
        end else begin
            host_end_r <= host_end_nxt;
            pin_four_r <= pin_four_nxt;
            pin_four_oe_r <= pin_four_oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // counter interrupt source and attention flag
    // ------------------------------------------------------------------

    // waits for the control output to go back high, so the last
    // handshake has completed before anyone is interrupted
    assign count_irq_src = zero & counter_used & i_handshake_control_out
        & ~zero_irq_disable_r;

    // shared flag for all sources of the card
    attention_flag u_attn (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_src_any(count_irq_src | i_other_irq_src),
        .i_clear(rd_bp_status),
        .o_flag(o_attention_request_flag)
    );

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------

    // status shows the live pin level, no latch behind it
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_count_lm) begin
            rdata_nxt = count[15:0];
        end else if (rd_count_hi) begin
            rdata_nxt = {count[23:16], 8'h00};
        end else if (rd_ctl) begin
            rdata_nxt[`STA_ZERO_BIT] = zero;
            rdata_nxt[`STA_HOST_END_BIT] = pin_four_r;
        end
    end

    // read data held until the next read
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 16'h0000;
        end else if (i_reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    assign o_reg_rdata = rdata_r;
    assign o_pin_four = pin_four_r;
    assign o_pin_four_oe = pin_four_oe_r;
    assign o_host_end_out = host_end_r;
    assign o_zero_count = zero;
    assign o_count_irq_src = count_irq_src;
    assign o_transfer_direction_bit = transfer_direction_bit_r;
endmodule

// ---- test/xfer_props.sv ----
// port-level checks for the transfer counter block
module xfer_props (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // register port
    input wire xfer_pkg::addr_type i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire xfer_pkg::data_type o_reg_rdata,
    // handshake and sources
    input wire logic i_handshake_control_out,
    input wire logic i_peripheral_end_in,
    input wire logic i_frontplane_disable,
    input wire logic i_other_irq_src,
    // outputs watched
    input wire logic o_handshake_enable,
    input wire logic o_pin_four,
    input wire logic o_host_end_out,
    input wire logic o_zero_count,
    input wire logic o_count_irq_src,
    input wire logic o_attention_request_flag
);
    import xfer_pkg::*;
    // one domain, so one clock and one disable
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // status register read strobe
    wire logic rd_bp = i_reg_rd && (i_reg_addr == 4'h9);
    wire logic rd_st = i_reg_rd && (i_reg_addr == 4'h7);
    wire logic src_any = o_count_irq_src || i_other_irq_src;

    a_gate_exact: assert property (o_handshake_enable == (!o_zero_count &&
        !i_peripheral_end_in && !i_frontplane_disable)) else $error("handshake gate wrong");
    a_irq_after_hs: assert property (o_count_irq_src |->
        o_zero_count && i_handshake_control_out) else $error("count irq too early");
    a_flag_clear: assert property (rd_bp |=> !o_attention_request_flag)
        else $error("flag not cleared by status read");
    a_flag_set: assert property ($rose(src_any) && !rd_bp |=> ##[0:1]
        o_attention_request_flag) else $error("flag not set by source");
    a_zero_host_end_out: assert property (o_zero_count |=> !o_host_end_out)
        else $error("host end not low at zero");
    a_status_live: assert property (rd_st |=> o_reg_rdata[1:0] ==
        {$past(o_pin_four), $past(o_zero_count)}) else $error("status bits wrong");
    a_reset_low: assert property ($fell(i_rst) |-> !o_host_end_out)
        else $error("host end high after reset");
    a_zero_sticky: assert property (o_zero_count && !i_reg_wr && !$past(i_reg_wr) &&
        !$past(i_reg_wr, 2) |=> o_zero_count) else $error("zero left without write");
endmodule

bind transfer_counter_end_signal xfer_props u_props (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_handshake_control_out(i_handshake_control_out),
    .i_peripheral_end_in(i_peripheral_end_in), .i_frontplane_disable(i_frontplane_disable),
    .i_other_irq_src(i_other_irq_src), .o_handshake_enable(o_handshake_enable),
    .o_pin_four(o_pin_four), .o_host_end_out(o_host_end_out), .o_zero_count(o_zero_count),
    .o_count_irq_src(o_count_irq_src), .o_attention_request_flag(o_attention_request_flag));

// ---- test/hs_model.sv ----
// peripheral plus handshake engine stand-in, prompt or slow
module hs_model (
    // clock
    input wire logic i_mclk,
    // controls from the bench
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic i_enable,
    // handshake control level, low = asserted
    output logic o_handshake_control_out,
    output int o_edges
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_handshake_control_out = 1'b1;
        o_edges = 0;
    end
    // enable is combinational, so look at it on the falling edge to avoid a race
    always begin
        @(negedge i_mclk);
        if (i_go && i_enable) begin
            @(posedge i_mclk);
            #1 o_handshake_control_out = 1'b0;
            o_edges++;
            repeat (i_slow ? 5 : 2) @(posedge i_mclk);
            #1 o_handshake_control_out = 1'b1;
            // idle gap long enough to see the counter stop us
            repeat (i_slow ? 6 : 3) @(posedge i_mclk);
        end
    end
endmodule

// ---- test/tb.sv ----
`include "xfer_consts.svh"
// self-checking bench for the transfer counter block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import xfer_pkg::*;
    logic i_mclk, i_rst, i_reg_wr, i_reg_rd, handshake_control_out, peripheral_end_in, fp_dis, fifo18, other, go, slow;
    addr_type i_reg_addr;
    data_type i_reg_wdata, rdata;
    logic hs_en, pin, pin_oe, host_end_out, zero, irq, dir, flag;
    int edges, e0, n, zdis, error_cnt, n_tests;
    count_type c;

    transfer_counter_end_signal DUT (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .i_handshake_control_out(handshake_control_out),
        .i_peripheral_end_in(peripheral_end_in), .i_frontplane_disable(fp_dis), .i_fifo_bit18(fifo18),
        .i_other_irq_src(other), .o_handshake_enable(hs_en), .o_pin_four(pin),
        .o_pin_four_oe(pin_oe), .o_host_end_out(host_end_out), .o_zero_count(zero),
        .o_count_irq_src(irq), .o_transfer_direction_bit(dir),
        .o_attention_request_flag(flag));
    hs_model periph (.i_mclk(i_mclk), .i_go(go), .i_slow(slow), .i_enable(hs_en),
        .o_handshake_control_out(handshake_control_out), .o_edges(edges));

    // 50 MHz clock
    always #10 i_mclk = ~i_mclk;

    // software programs n transfers with the 0x00ffff offset
    function automatic count_type cnt_for(input int k);
        return 24'h00ffff + 24'(k);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // every task leaves us 1 ns after a rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask
    task automatic reg_wr(input addr_type a, input data_type d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        tick(1);
        i_reg_wr = 1'b0;
        tick(1);
    endtask
    // read data lands on the taking edge; the task checks it one cycle later
    task automatic reg_rd(input addr_type a, input data_type m, input data_type e);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        tick(1);
        i_reg_rd = 1'b0;
        tick(1);
        chk(rdata & m, e);
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watchdog at 20000 cycles, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end

    initial begin
        {i_mclk, i_reg_wr, i_reg_rd, peripheral_end_in, fp_dis, other, go, slow} = 8'h00;
        {i_rst, fifo18} = 2'b11;
        i_reg_addr = 4'h0;
        i_reg_wdata = 16'h0000;
        error_cnt = 0;
        n_tests = 0;
        void'($urandom(81));
        repeat (5) @(posedge i_mclk);
        #1 i_rst = 1'b0;
        tick(1);
        chk(host_end_out, 1'b0);
        chk(pin_oe, 1'b0);
        chk(dir, 1'b1);
        reg_rd(`OFS_COUNT_LM, 16'hffff, 16'hffff);
        reg_rd(`OFS_COUNT_HI_CTL2, 16'hffff, 16'hff00);
        reg_rd(`OFS_CTL_STATUS, 16'h0003, 16'h0000);
        reg_rd(4'h3, 16'hffff, 16'h0000);
        // counted input transfers, random length and speed
        for (int it = 0; it < 3; it++) begin
            n = 1 + $urandom % 6;
            slow = 1'($urandom % 2);
            zdis = (it == 1);
            c = cnt_for(n);
            reg_wr(`OFS_COUNT_LM, c[15:0]);
            reg_wr(`OFS_COUNT_HI_CTL2, {c[23:16], 8'h02});
            reg_wr(`OFS_CTL_STATUS, 16'h0082 | 16'(zdis));
            reg_wr(`OFS_CTL_STATUS, 16'h0080 | 16'(zdis));
            chk(host_end_out, 1'b1);
            chk({pin_oe, pin}, 2'b11);
            // a disabled frontplane or a peripheral end blocks every handshake
            e0 = edges;
            if (it % 2) peripheral_end_in = 1'b1;
            else fp_dis = 1'b1;
            go = 1'b1;
            tick(15);
            chk(16'(edges - e0), 16'h0000);
            {peripheral_end_in, fp_dis} = 2'b00;
            for (int k = 0; k < 300 && !(zero === 1'b1 && handshake_control_out); k++) tick(1);
            tick(3);
            go = 1'b0;
            chk(16'(edges - e0), 16'(n));
            chk({host_end_out, pin}, 2'b00);
            chk(flag, zdis == 0);
            reg_rd(`OFS_COUNT_LM, 16'hffff, 16'hffff);
            reg_rd(`OFS_COUNT_HI_CTL2, 16'hffff, 16'h0000);
            reg_rd(`OFS_CTL_STATUS, 16'h0003, 16'h0001);
            reg_rd(`OFS_BP_STATUS, 16'hffff, 16'h0000);
            chk(flag, 1'b0);
            tick(3);
            chk(flag, 1'b0);
            reg_wr(`OFS_CTL_STATUS, 16'h0082 | 16'(zdis));
            tick(2);
            reg_rd(`OFS_COUNT_LM, 16'hffff, c[15:0]);
            chk(host_end_out, 1'b1);
        end
        // output without the counter: fifo bit 18 drives host end
        reg_wr(`OFS_COUNT_HI_CTL2, 16'h0003);
        reg_wr(`OFS_CTL_STATUS, 16'h0002);
        fifo18 = 1'b0;
        tick(3);
        chk({host_end_out, pin_oe, dir}, 3'b010);
        chk(hs_en, 1'b1);
        reg_rd(`OFS_COUNT_LM, 16'hffff, 16'hffff);
        fifo18 = 1'b1;
        tick(3);
        chk(host_end_out, 1'b1);
        // option off: pin four shows the plain control bit
        reg_wr(`OFS_COUNT_HI_CTL2, 16'h0001);
        reg_wr(`OFS_CTL_STATUS, 16'h0012);
        tick(2);
        chk(pin, 1'b1);
        // another source sets the flag, status read clears it
        other = 1'b1;
        tick(3);
        chk(flag, 1'b1);
        reg_rd(`OFS_BP_STATUS, 16'hffff, 16'h0000);
        chk(flag, 1'b0);
        other = 1'b0;
        // second reset mid run
        i_rst = 1'b1;
        tick(2);
        i_rst = 1'b0;
        tick(1);
        chk(host_end_out, 1'b0);
        reg_rd(`OFS_COUNT_HI_CTL2, 16'hffff, 16'hff00);
        stop_test();
    end
endmodule
